// ==== mcr_config_regs.sv ====
// module: configuration register bank of the metering core
// Functional notes
// - noload_disable bit 0 turns off active no-load detection; resets 0.
// - noload_disable bit 1 turns off reactive no-load detection; resets 0.
// - noload_disable bit 2 turns off apparent no-load detection; resets 0.
// - line_cycle_mode bits 0,1 enable active line-cycle mode, A and B.
// - line_cycle_mode bits 2,3 enable reactive line-cycle mode, A and B.
// - line_cycle_mode bits 4,5 enable apparent line-cycle mode, A and B.
// - bit 6 read-clear enable resets 1; set makes supported reads clear.
// - config bits 0,1 enable integrators on channels A and B; reset 0.
// - config bit 2 enables high-pass on all channels; resets 1.
// - config bit 3 picks power factor source: instant or line-cycle.
// - config bit 4 picks pulse output that updates reverse indication.
// - config bit 5: reverse pin level when 0, 1 Hz pulse when 1.
// - config bit 6 zero-cross filter: 0 enabled, 1 bypassed; resets 0.
// - writing 1 to config bit 7 triggers a software reset.
// - config bit 8 enables the register checksum; resets 0.
// - config bits 10:9 set power low-pass time 250ms..2s; resets 00.
// - config bit 11 picks current zero-cross source channel A or B.
// - config bits 13:12 zero-cross edge: 00/11 both, 01 neg, 10 pos.
// - config bit 15 lock off when 1, resets 1; bit 14 reads 0.
`timescale 1ns/1ns
module mcr_config_regs #(
    parameter int unsigned REV_HALF_CYCLES = mcr_pkg::REV_HALF_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register access from the host port logic
    input wire logic [9:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // metering core events
    input wire logic reverse_sign_in,
    input wire logic pulse_output_one_in,
    input wire logic pulse_output_two_in,
    input wire logic volt_zero_cross_pos_in,
    input wire logic volt_zero_cross_neg_in,
    input wire logic chan_a_zero_cross_in,
    input wire logic chan_b_zero_cross_in,
    // no-load controls
    output logic active_noload_off_out,
    output logic reactive_noload_off_out,
    output logic apparent_noload_off_out,
    // line-cycle controls
    output logic [5:0] linecycle_enable_out,
    output logic read_clears_enable_out,
    // signal path controls
    output logic chan_a_integrator_on_out,
    output logic chan_b_integrator_on_out,
    output logic highpass_on_out,
    output logic power_factor_source_out,
    output logic zero_cross_filter_bypass_out,
    output logic checksum_on_out,
    output logic [1:0] power_lowpass_time_out,
    output logic [11:0] power_lowpass_ms_out,
    output logic host_port_lock_on_out,
    output logic software_reset_out,
    // derived pins
    output logic reverse_power_pin_out,
    output logic current_zero_cross_out,
    output logic zero_cross_event_out
);
    logic [7:0] noload_disable;
    logic [7:0] line_cycle_mode;
    logic [15:0] device_configuration;
    logic wr_noload;
    logic wr_lcm;
    logic wr_cfg;
    logic soft_rst;
    logic bank_rst;
    logic rev_flag;
    logic rev_tick;
    logic rev_run;
    logic [1:0] edge_sel;
    logic [15:0] next_rdata;
    mcr_pkg::mcr_rev_state_t rev_state;
    mcr_pkg::mcr_rev_state_t next_rev_state;

    // -----
    // write decode
    // -----
    assign wr_noload = reg_wr_in &&
        reg_addr_in == mcr_pkg::OFS_NOLOAD_DISABLE;
    assign wr_lcm = reg_wr_in &&
        reg_addr_in == mcr_pkg::OFS_LINE_CYCLE_MODE;
    assign wr_cfg = reg_wr_in &&
        reg_addr_in == mcr_pkg::OFS_DEVICE_CONFIGURATION;
    // the trigger bit is never stored; it only fires the reset
    assign soft_rst = wr_cfg &&
        reg_wdata_in[mcr_pkg::BIT_SOFTWARE_RESET_TRIGGER];
    // soft reset lands one cycle after the write, as a registered pulse
    assign bank_rst = rst_in || software_reset_out;

    // -----
    // software reset pulse
    // -----
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            software_reset_out <= 1'b0;
        end else begin
            software_reset_out <= soft_rst;
        end
    end

    // -----
    // noload_disable
    // -----
    always_ff @(posedge clk_in) begin
        if (bank_rst) begin
            noload_disable <= mcr_pkg::RST_NOLOAD_DISABLE;
        end else if (wr_noload) begin
            noload_disable <= reg_wdata_in[7:0] &
                mcr_pkg::MASK_NOLOAD_DISABLE;
        end
    end

    assign active_noload_off_out =
        noload_disable[mcr_pkg::BIT_ACTIVE_NOLOAD_OFF];
    assign reactive_noload_off_out =
        noload_disable[mcr_pkg::BIT_REACTIVE_NOLOAD_OFF];
    assign apparent_noload_off_out =
        noload_disable[mcr_pkg::BIT_APPARENT_NOLOAD_OFF];

    // -----
    // line_cycle_mode
    // -----
    always_ff @(posedge clk_in) begin
        if (bank_rst) begin
            line_cycle_mode <= mcr_pkg::RST_LINE_CYCLE_MODE;
        end else if (wr_lcm) begin
            line_cycle_mode <= reg_wdata_in[7:0] &
                mcr_pkg::MASK_LINE_CYCLE_MODE;
        end
    end

    // even bits channel A, odd bits channel B, paired per energy type
    genvar gi;
    generate
        for (gi = 0; gi < mcr_pkg::LCM_ENABLES; gi++) begin : g_lcm
            assign linecycle_enable_out[gi] =
                line_cycle_mode[gi];
        end
    endgenerate

    // these three registers are not read-clear themselves
    assign read_clears_enable_out =
        line_cycle_mode[mcr_pkg::BIT_READ_CLEARS_ENABLE];

    // -----
    // device_configuration
    // -----
    always_ff @(posedge clk_in) begin
        if (bank_rst) begin
            device_configuration <=
                mcr_pkg::RST_DEVICE_CONFIGURATION;
        end else if (wr_cfg) begin
            // bit 7 and bit 14 masked off: they always read zero
            device_configuration <= reg_wdata_in &
                mcr_pkg::MASK_DEVICE_CONFIGURATION;
        end
    end

    assign chan_a_integrator_on_out =
        device_configuration[mcr_pkg::BIT_CHAN_A_INTEGRATOR_ON];
    assign chan_b_integrator_on_out =
        device_configuration[mcr_pkg::BIT_CHAN_B_INTEGRATOR_ON];
    assign highpass_on_out =
        device_configuration[mcr_pkg::BIT_HIGHPASS_ON];
    assign power_factor_source_out =
        device_configuration[mcr_pkg::BIT_POWER_FACTOR_SOURCE];
    assign zero_cross_filter_bypass_out =
        device_configuration[mcr_pkg::BIT_ZERO_CROSS_FILTER_BYPASS];
    assign checksum_on_out =
        device_configuration[mcr_pkg::BIT_CHECKSUM_ON];
    assign power_lowpass_time_out = device_configuration[
        mcr_pkg::LSB_POWER_LOWPASS_TIME +: 2];
    // inverted sense: stored 1 means locking is off
    always_ff @(posedge clk_in) begin
        if (bank_rst) begin
            host_port_lock_on_out <= ~mcr_pkg::RST_DEVICE_CONFIGURATION[
                mcr_pkg::BIT_HOST_PORT_LOCK_OFF];
        end else if (wr_cfg) begin
            host_port_lock_on_out <=
                ~reg_wdata_in[mcr_pkg::BIT_HOST_PORT_LOCK_OFF];
        end
    end
    assign edge_sel = device_configuration[
        mcr_pkg::LSB_ZERO_CROSS_EDGE_SELECT +: 2];

    // -----
    // low-pass settling time in ms, for the power filter
    // -----
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            power_lowpass_ms_out <= mcr_pkg::LPF_MS_0;
        end else begin
            case (power_lowpass_time_out)
                2'h0: power_lowpass_ms_out <= mcr_pkg::LPF_MS_0;
                2'h1: power_lowpass_ms_out <= mcr_pkg::LPF_MS_1;
                2'h2: power_lowpass_ms_out <= mcr_pkg::LPF_MS_2;
                default: power_lowpass_ms_out <= mcr_pkg::LPF_MS_3;
            endcase
        end
    end

    // -----
    // register read
    // -----
    always_comb begin
        next_rdata = 16'h0000;
        case (reg_addr_in)
            mcr_pkg::OFS_NOLOAD_DISABLE: begin
                next_rdata = {8'h00, noload_disable};
            end
            mcr_pkg::OFS_LINE_CYCLE_MODE: begin
                next_rdata = {8'h00, line_cycle_mode};
            end
            mcr_pkg::OFS_DEVICE_CONFIGURATION: begin
                next_rdata = device_configuration;
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // reads here never clear; clearing belongs to result registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    // -----
    // reverse-power indication
    // -----
    // sign sampled only on the chosen pulse output, so the pin follows
    // that pulse train rather than raw power noise
    always_ff @(posedge clk_in) begin
        if (bank_rst) begin
            rev_flag <= 1'b0;
        end else if (device_configuration[
                mcr_pkg::BIT_REVERSE_POWER_PULSE_SELECT]) begin
            if (pulse_output_two_in) begin
                rev_flag <= reverse_sign_in;
            end
        end else if (pulse_output_one_in) begin
            rev_flag <= reverse_sign_in;
        end
    end

    assign rev_run = rev_state == mcr_pkg::REV_PULSE_HI ||
        rev_state == mcr_pkg::REV_PULSE_LO;

    mcr_tick_div #(
        .CYCLES(REV_HALF_CYCLES)
    ) u_rev_div (
        .clk_in(clk_in),
        .rst_in(bank_rst),
        .run_in(rev_run),
        .tick_out(rev_tick)
    );

    always_comb begin
        next_rev_state = rev_state;
        case (rev_state)
            mcr_pkg::REV_LOW: begin
                if (rev_flag) begin
                    next_rev_state = device_configuration[
                        mcr_pkg::BIT_REVERSE_POWER_PULSED] ?
                        mcr_pkg::REV_PULSE_HI : mcr_pkg::REV_LEVEL;
                end
            end
            mcr_pkg::REV_LEVEL: begin
                if (!rev_flag) begin
                    next_rev_state = mcr_pkg::REV_LOW;
                end else if (device_configuration[
                        mcr_pkg::BIT_REVERSE_POWER_PULSED]) begin
                    next_rev_state = mcr_pkg::REV_PULSE_HI;
                end
            end
            mcr_pkg::REV_PULSE_HI: begin
                if (!rev_flag || !device_configuration[
                        mcr_pkg::BIT_REVERSE_POWER_PULSED]) begin
                    next_rev_state = mcr_pkg::REV_LOW;
                end else if (rev_tick) begin
                    next_rev_state = mcr_pkg::REV_PULSE_LO;
                end
            end
            mcr_pkg::REV_PULSE_LO: begin
                if (!rev_flag || !device_configuration[
                        mcr_pkg::BIT_REVERSE_POWER_PULSED]) begin
                    next_rev_state = mcr_pkg::REV_LOW;
                end else if (rev_tick) begin
                    next_rev_state = mcr_pkg::REV_PULSE_HI;
                end
            end
            default: begin
                next_rev_state = mcr_pkg::REV_LOW;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (bank_rst) begin
            rev_state <= mcr_pkg::REV_LOW;
        end else begin
            rev_state <= next_rev_state;
        end
    end

    // pin is high only in the level state or the high half of the pulse
    always_ff @(posedge clk_in) begin
        if (bank_rst) begin
            reverse_power_pin_out <= 1'b0;
        end else begin
            reverse_power_pin_out <= next_rev_state == mcr_pkg::REV_LEVEL ||
                next_rev_state == mcr_pkg::REV_PULSE_HI;
        end
    end

    // -----
    // zero-crossing selection
    // -----
    always_ff @(posedge clk_in) begin
        if (bank_rst) begin
            current_zero_cross_out <= 1'b0;
            zero_cross_event_out <= 1'b0;
        end else begin
            current_zero_cross_out <= device_configuration[
                mcr_pkg::BIT_CURRENT_ZERO_CROSS_SOURCE] ?
                chan_b_zero_cross_in : chan_a_zero_cross_in;
            case (edge_sel)
                mcr_pkg::EDGE_NEG_ONLY: begin
                    zero_cross_event_out <= volt_zero_cross_neg_in;
                end
                mcr_pkg::EDGE_POS_ONLY: begin
                    zero_cross_event_out <= volt_zero_cross_pos_in;
                end
                default: begin
                    zero_cross_event_out <= volt_zero_cross_pos_in ||
                        volt_zero_cross_neg_in;
                end
            endcase
        end
    end
endmodule // mcr_config_regs

// ==== mcr_pkg.sv ====
// package: offsets, field positions, reset values and timing of the config bank
package mcr_pkg;

    // -----
    // register map
    // -----
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 16;
    localparam logic [9:0] OFS_NOLOAD_DISABLE = 10'h001;
    localparam logic [9:0] OFS_LINE_CYCLE_MODE = 10'h004;
    localparam logic [9:0] OFS_DEVICE_CONFIGURATION = 10'h102;

    // -----
    // reset values
    // -----
    localparam logic [7:0] RST_NOLOAD_DISABLE = 8'h00;
    localparam logic [7:0] RST_LINE_CYCLE_MODE = 8'h40;
    localparam logic [15:0] RST_DEVICE_CONFIGURATION = 16'h8004;

    // -----
    // writable masks, reserved bits read zero
    // -----
    localparam logic [7:0] MASK_NOLOAD_DISABLE = 8'h07;
    localparam logic [7:0] MASK_LINE_CYCLE_MODE = 8'h7F;
    localparam logic [15:0] MASK_DEVICE_CONFIGURATION = 16'hBF7F;

    // -----
    // noload_disable fields
    // -----
    localparam int unsigned BIT_ACTIVE_NOLOAD_OFF = 0;
    localparam int unsigned BIT_REACTIVE_NOLOAD_OFF = 1;
    localparam int unsigned BIT_APPARENT_NOLOAD_OFF = 2;

    // -----
    // line_cycle_mode fields
    // -----
    localparam int unsigned LCM_ENABLES = 6;
    localparam int unsigned BIT_READ_CLEARS_ENABLE = 6;

    // -----
    // device_configuration fields
    // -----
    localparam int unsigned BIT_CHAN_A_INTEGRATOR_ON = 0;
    localparam int unsigned BIT_CHAN_B_INTEGRATOR_ON = 1;
    localparam int unsigned BIT_HIGHPASS_ON = 2;
    localparam int unsigned BIT_POWER_FACTOR_SOURCE = 3;
    localparam int unsigned BIT_REVERSE_POWER_PULSE_SELECT = 4;
    localparam int unsigned BIT_REVERSE_POWER_PULSED = 5;
    localparam int unsigned BIT_ZERO_CROSS_FILTER_BYPASS = 6;
    localparam int unsigned BIT_SOFTWARE_RESET_TRIGGER = 7;
    localparam int unsigned BIT_CHECKSUM_ON = 8;
    localparam int unsigned LSB_POWER_LOWPASS_TIME = 9;
    localparam int unsigned BIT_CURRENT_ZERO_CROSS_SOURCE = 11;
    localparam int unsigned LSB_ZERO_CROSS_EDGE_SELECT = 12;
    localparam int unsigned BIT_HOST_PORT_LOCK_OFF = 15;

    // -----
    // zero-cross edge codes
    // -----
    localparam logic [1:0] EDGE_BOTH_LO = 2'h0;
    localparam logic [1:0] EDGE_NEG_ONLY = 2'h1;
    localparam logic [1:0] EDGE_POS_ONLY = 2'h2;
    localparam logic [1:0] EDGE_BOTH_HI = 2'h3;

    // -----
    // power low-pass settling times, in ms
    // -----
    localparam logic [11:0] LPF_MS_0 = 12'h0FA;
    localparam logic [11:0] LPF_MS_1 = 12'h1F4;
    localparam logic [11:0] LPF_MS_2 = 12'h3E8;
    localparam logic [11:0] LPF_MS_3 = 12'h7D0;

    // -----
    // timing
    // -----
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned REV_PULSE_HZ = 1;
    localparam longint unsigned REV_PERIOD_NS =
        64'h3B9ACA00 / REV_PULSE_HZ;
    localparam int unsigned REV_HALF_CYCLES =
        32'(REV_PERIOD_NS / 64'h2 / CLK_PERIOD_NS);

    // -----
    // reverse-power pin states
    // -----
    typedef enum logic [3:0] {
        REV_LOW = 4'b0001,
        REV_LEVEL = 4'b0010,
        REV_PULSE_HI = 4'b0100,
        REV_PULSE_LO = 4'b1000
    } mcr_rev_state_t;

endpackage

// ==== mcr_tick_div.sv ====
// module: cycle divider giving a one-cycle enable pulse
`timescale 1ns/1ns
module mcr_tick_div #(
    parameter int unsigned CYCLES = 50000000
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic run_in,
    // enable pulse
    output logic tick_out
);
    logic [31:0] count;

    // -----
    // divider
    // -----
    // held at zero while idle so every run starts a full period
    always_ff @(posedge clk_in) begin
        if (rst_in || !run_in) begin
            count <= 32'h0;
            tick_out <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick_out <= 1'b0;
        end
    end
endmodule // mcr_tick_div

// ==== mcr_config_regs_assertions.sv ====
// checker: port-level timing relations of the configuration bank
`timescale 1ns/1ns
module mcr_config_regs_assertions (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [9:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // events
    input wire logic reverse_sign_in,
    input wire logic pulse_output_one_in,
    input wire logic pulse_output_two_in,
    input wire logic volt_zero_cross_pos_in,
    input wire logic volt_zero_cross_neg_in,
    input wire logic chan_a_zero_cross_in,
    input wire logic chan_b_zero_cross_in,
    // controls
    input wire logic active_noload_off_out,
    input wire logic reactive_noload_off_out,
    input wire logic apparent_noload_off_out,
    input wire logic [5:0] linecycle_enable_out,
    input wire logic read_clears_enable_out,
    input wire logic chan_a_integrator_on_out,
    input wire logic chan_b_integrator_on_out,
    input wire logic highpass_on_out,
    input wire logic power_factor_source_out,
    input wire logic zero_cross_filter_bypass_out,
    input wire logic checksum_on_out,
    input wire logic [1:0] power_lowpass_time_out,
    input wire logic [11:0] power_lowpass_ms_out,
    input wire logic host_port_lock_on_out,
    input wire logic software_reset_out,
    input wire logic reverse_power_pin_out,
    input wire logic current_zero_cross_out,
    input wire logic zero_cross_event_out
);
    // -----
    // helpers
    // -----
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [15:0] wd_q;
    logic wr_nl, wr_lc, wr_cf;
    // a reset pulse at the write edge wins, so such writes are skipped
    assign wr_nl = reg_wr_in && !software_reset_out &&
        reg_addr_in == mcr_pkg::OFS_NOLOAD_DISABLE;
    assign wr_lc = reg_wr_in && !software_reset_out &&
        reg_addr_in == mcr_pkg::OFS_LINE_CYCLE_MODE;
    assign wr_cf = reg_wr_in && !software_reset_out &&
        reg_addr_in == mcr_pkg::OFS_DEVICE_CONFIGURATION;
    always_ff @(posedge clk_in) begin
        wd_q <= reg_wdata_in;
    end
    function automatic logic [11:0] lpf_ms(input logic [1:0] t);
        return 12'h0FA << t;
    endfunction
    sequence s_rst_pulse; software_reset_out; endsequence
    sequence s_defaults;
        highpass_on_out && !host_port_lock_on_out &&
            !chan_a_integrator_on_out && read_clears_enable_out;
    endsequence
    // -----
    // properties
    // -----
    property p_nl; wr_nl |=> {apparent_noload_off_out,
        reactive_noload_off_out, active_noload_off_out} == wd_q[2:0];
    endproperty
    a_nl: assert property (p_nl)
        else $error("noload write lost");
    property p_lc; wr_lc |=> {read_clears_enable_out,
        linecycle_enable_out} == wd_q[6:0]; endproperty
    a_lc: assert property (p_lc)
        else $error("line mode write lost");
    property p_cf; wr_cf && !reg_wdata_in[7] |=> {checksum_on_out,
        zero_cross_filter_bypass_out, power_factor_source_out,
        highpass_on_out, chan_b_integrator_on_out, chan_a_integrator_on_out,
        host_port_lock_on_out} == {wd_q[8], wd_q[6], wd_q[3:0], !wd_q[15]};
    endproperty
    a_cf: assert property (p_cf)
        else $error("config write lost");
    property p_software_reset_trigger; wr_cf && reg_wdata_in[7] |=> s_rst_pulse ##1 s_defaults;
    endproperty
    a_software_reset_trigger: assert property (p_software_reset_trigger)
        else $error("soft reset missing");
    property p_rv; 1 |=> reg_rvalid_out == $past(reg_rd_in); endproperty
    a_rv: assert property (p_rv) else $error("read valid timing");
    property p_rsv; reg_rvalid_out |-> !reg_rdata_out[14]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_lpf; 1 |=> power_lowpass_ms_out ==
        lpf_ms($past(power_lowpass_time_out)); endproperty
    a_lpf: assert property (p_lpf) else $error("lowpass time wrong");
    property p_zsrc; chan_a_zero_cross_in == chan_b_zero_cross_in &&
        !software_reset_out |=> current_zero_cross_out ==
        $past(chan_a_zero_cross_in); endproperty
    a_zsrc: assert property (p_zsrc) else $error("zero cross src");
    property p_zx; !volt_zero_cross_pos_in && !volt_zero_cross_neg_in
        |=> !zero_cross_event_out; endproperty
    a_zx: assert property (p_zx) else $error("spurious zero cross");
    property p_rclr; !reverse_sign_in && pulse_output_one_in &&
        pulse_output_two_in |-> ##2 !reverse_power_pin_out; endproperty
    a_rclr: assert property (p_rclr) else $error("rev pin stuck");
endmodule // mcr_config_regs_assertions

bind mcr_config_regs mcr_config_regs_assertions u_chk (.*);

// ==== mcr_config_regs_tb.sv ====
// testbench: self-checking run of the configuration bank
`timescale 1ns/1ns
module mcr_config_regs_tb;
    // short pulse period keeps the run brief
    localparam int unsigned HALF = 8;
    localparam logic [9:0] NL = mcr_pkg::OFS_NOLOAD_DISABLE;
    localparam logic [9:0] LC = mcr_pkg::OFS_LINE_CYCLE_MODE;
    localparam logic [9:0] CF = mcr_pkg::OFS_DEVICE_CONFIGURATION;
    logic clk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [9:0] reg_addr_in = 10'h000;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out;
    logic reverse_sign_in = 1'b0, pulse_output_one_in = 1'b0;
    logic pulse_output_two_in = 1'b0, volt_zero_cross_pos_in = 1'b0;
    logic volt_zero_cross_neg_in = 1'b0, chan_a_zero_cross_in = 1'b0;
    logic chan_b_zero_cross_in = 1'b0, reg_rvalid_out, read_clears_enable_out;
    logic active_noload_off_out, reactive_noload_off_out;
    logic apparent_noload_off_out, chan_a_integrator_on_out, highpass_on_out;
    logic chan_b_integrator_on_out, power_factor_source_out, checksum_on_out;
    logic zero_cross_filter_bypass_out, host_port_lock_on_out;
    logic software_reset_out, reverse_power_pin_out, current_zero_cross_out;
    logic zero_cross_event_out;
    logic [5:0] linecycle_enable_out;
    logic [1:0] power_lowpass_time_out;
    logic [11:0] power_lowpass_ms_out;
    logic [15:0] exp_q[$];
    int n_fail = 0;
    int check_count = 0;
    mcr_config_regs #(.REV_HALF_CYCLES(HALF)) dut (.*);
    initial forever #5 clk_in = ~clk_in;
    // -----
    // tasks
    // -----
    task automatic check(input string nm, input logic [15:0] s, e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
    endtask
    task automatic fire(input logic sg, one, two, exp_pin);
        @(posedge clk_in);
        reverse_sign_in <= sg;
        pulse_output_one_in <= one;
        pulse_output_two_in <= two;
        @(posedge clk_in);
        pulse_output_one_in <= 1'b0;
        pulse_output_two_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 check("reverse pin", 16'(reverse_power_pin_out),
            16'(exp_pin));
    endtask
    task automatic toggles(input int span, lo, hi);
        int n;
        logic last;
        n = 0;
        last = reverse_power_pin_out;
        repeat (span) begin
            @(posedge clk_in);
            #1 n += int'(reverse_power_pin_out !== last);
            last = reverse_power_pin_out;
        end
        check("pin toggles", 16'(n >= lo && n <= hi), 16'h0001);
    endtask
    task automatic conclude();
        check("reads left", 16'(exp_q.size()), 16'h0000);
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // read data is compared in arrival order
    always @(posedge clk_in) begin
        if (reg_rvalid_out === 1'b1)
            check("rdata", reg_rdata_out, exp_q.pop_front());
    end
    initial begin
        #300000;
        n_fail++;
        conclude();
    end
    // -----
    // main sequence
    // -----
    initial begin
        logic [15:0] d;
        void'($urandom(3));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(NL, 16'h0000);
        rd(LC, 16'h0040);
        wr(10'h3FF, 16'hFFFF);
        rd(10'h3FF, 16'h0000);
        rd(CF, 16'h8004);
        repeat (6) begin
            d = 16'($urandom);
            wr(NL, d);
            rd(NL, d & 16'h0007);
            wr(LC, d);
            rd(LC, d & 16'h007F);
            d[7] = 1'b0;
            wr(CF, d);
            rd(CF, d & 16'hBF7F);
            #1 check("lock", 16'(host_port_lock_on_out),
                16'(!d[15]));
        end
        for (int t = 0; t < 4; t++) begin
            wr(CF, 16'h8004 | 16'(t << 9));
            repeat (2) @(posedge clk_in);
            #1 check("lpf ms", 16'(power_lowpass_ms_out),
                16'(12'h0FA << t));
        end
        for (int c = 0; c < 4; c++) begin
            wr(CF, 16'h8004 | 16'(c << 12));
            volt_zero_cross_pos_in <= 1'b1;
            @(posedge clk_in);
            volt_zero_cross_pos_in <= 1'b0;
            volt_zero_cross_neg_in <= 1'b1;
            #1 check("zx pos", 16'(zero_cross_event_out),
                16'(c != 1));
            @(posedge clk_in);
            volt_zero_cross_neg_in <= 1'b0;
            #1 check("zx neg", 16'(zero_cross_event_out),
                16'(c != 2));
        end
        for (int s = 0; s < 2; s++) begin
            wr(CF, 16'h8004 | 16'(s << 11));
            chan_a_zero_cross_in <= 1'b1;
            chan_b_zero_cross_in <= 1'b0;
            repeat (2) @(posedge clk_in);
            #1 check("izx", 16'(current_zero_cross_out), 16'(s == 0));
        end
        wr(CF, 16'h8004);
        fire(1'b1, 1'b0, 1'b1, 1'b0);
        fire(1'b1, 1'b1, 1'b0, 1'b1);
        toggles(20, 0, 0);
        fire(1'b0, 1'b1, 1'b0, 1'b0);
        wr(CF, 16'h8034);
        fire(1'b1, 1'b1, 1'b0, 1'b0);
        fire(1'b1, 1'b0, 1'b1, 1'b1);
        toggles(40, 3, 5);
        fire(1'b0, 1'b1, 1'b1, 1'b0);
        wr(NL, 16'h0007);
        wr(CF, 16'h0083);
        #1 check("software_reset_trigger", 16'(software_reset_out), 16'h0001);
        rd(CF, 16'h8004);
        rd(NL, 16'h0000);
        repeat (4) @(posedge clk_in);
        conclude();
    end
endmodule // mcr_config_regs_tb
